// file: core/asap_counter.v
// Down counter used for every timed phase of the controller
`timescale 1ns/1ps
module asap_counter #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_rst,
  // Control
  input  wire         i_load,
  input  wire [W-1:0] i_value,
  // Status
  output reg          o_done
);
  reg [W-1:0] count;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count  <= {W{1'b0}};
      o_done <= 1'b0;
    end
    else if (i_load)
    begin
      count  <= i_value;
      o_done <= (i_value == {W{1'b0}});
    end
    else if (count != {W{1'b0}})
    begin
      count  <= count - {{(W-1){1'b0}}, 1'b1};
      o_done <= (count == {{(W-1){1'b0}}, 1'b1});
    end
    else
    begin
      o_done <= 1'b1;
    end
  end
endmodule

// file: core/asap_ctrl.v
// Host controller sequencing reads and writes of an asynchronous static memory
`timescale 1ns/1ps
`include "asap_map.vh"
module asap_ctrl #(
  parameter AW        = `ASAP_ADDR_W,
  parameter DW        = `ASAP_DATA_W,
  parameter POWER_CYC = `ASAP_POWER_CYC,
  parameter CW        = 16
) (
  // Clock and reset
  input  wire          i_clk,
  input  wire          i_rst,
  // User request
  input  wire          i_req,
  input  wire          i_we,
  input  wire [AW-1:0] i_addr,
  input  wire [DW-1:0] i_wdata,
  output reg           o_ready,
  output reg           o_done,
  output reg  [DW-1:0] o_rdata,
  // Memory pins
  output reg           o_chip_select_low_active_n,
  output reg           o_chip_select_high_active,
  output reg           o_output_enable_n,
  output reg           o_write_strobe_n,
  output reg  [AW-1:0] o_mem_addr,
  input  wire [DW-1:0] i_shared_data_lines,
  output reg  [DW-1:0] o_shared_data_lines,
  output reg           o_shared_data_lines_oe
);
  // Each phase lasts at least one cycle, so n cycles are loaded as n-1
  function [CW-1:0] cyc;
    input integer ps;
    integer c;
    begin
      c = `ASAP_CYC(ps);
      if (c < 1)
        c = 1;
      cyc = c[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  function integer max2;
    input integer a;
    input integer b;
    begin
      max2 = (a > b) ? a : b;
    end
  endfunction

  localparam [2:0] ST_POWER = 3'h0;
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_RD    = 3'h2;
  localparam [2:0] ST_WR    = 3'h3;
  localparam [2:0] ST_WEND  = 3'h4;
  localparam [2:0] ST_REC   = 3'h5;

  // Read waits the slowest of address, select and enable paths
  localparam integer RD_PS  = max2(max2(`ASAP_T_AA_PS, `ASAP_T_ACE_PS), `ASAP_T_DOE_PS);
  // Strobe low long enough for pulse width, select, address and data setup
  localparam integer WR_PS  = max2(max2(`ASAP_T_PWE_PS, `ASAP_T_SCE_PS),
                                   max2(`ASAP_T_AW_PS, `ASAP_T_SD_PS));
  // Recovery covers bus release by the memory and cycle spacing
  localparam integer REC_PS = max2(max2(`ASAP_T_HZOE_PS, `ASAP_T_HZWE_PS),
                                   max2(`ASAP_T_WC_PS, `ASAP_T_RC_PS));
  // CW has to hold POWER_CYC; the default covers one millisecond at 40 MHz
  // The load edge is itself a cycle of the wait, so one less is loaded
  localparam integer  POWER_M1   = POWER_CYC - 1;
  localparam [CW-1:0] POWER_LOAD = POWER_M1[CW-1:0];

  reg  [2:0]    state;
  reg  [2:0]    next_state;
  reg           power_armed;
  reg           cnt_load;
  reg  [CW-1:0] cnt_value;
  wire          cnt_done;

  asap_counter #(
    .W (CW)
  ) u_cnt (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (cnt_load),
    .i_value (cnt_value),
    .o_done  (cnt_done)
  );

  always @*
  begin
    next_state = state;
    cnt_load   = 1'b0;
    cnt_value  = {CW{1'b0}};
    case (state)
      ST_POWER:
      begin
        // Power wait is loaded once, on the first edge after reset
        if (!power_armed)
        begin
          cnt_load  = 1'b1;
          cnt_value = POWER_LOAD;
        end
        else if (cnt_done)
        begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (i_req)
        begin
          cnt_load   = 1'b1;
          next_state = i_we ? ST_WR : ST_RD;
          cnt_value  = i_we ? cyc(WR_PS) : cyc(RD_PS);
        end
      end
      ST_RD:
      begin
        if (cnt_done)
        begin
          cnt_load   = 1'b1;
          cnt_value  = cyc(REC_PS);
          next_state = ST_REC;
        end
      end
      ST_WR:
      begin
        if (cnt_done)
          next_state = ST_WEND;
      end
      ST_WEND:
      begin
        cnt_load   = 1'b1;
        cnt_value  = cyc(REC_PS);
        next_state = ST_REC;
      end
      ST_REC:
      begin
        if (cnt_done)
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state                      <= ST_POWER;
      power_armed                <= 1'b0;
      o_ready                    <= 1'b0;
      o_done                     <= 1'b0;
      o_rdata                    <= {DW{1'b0}};
      o_chip_select_low_active_n <= 1'b1;
      o_chip_select_high_active  <= 1'b0;
      o_output_enable_n          <= 1'b1;
      o_write_strobe_n           <= 1'b1;
      o_mem_addr                 <= {AW{1'b0}};
      o_shared_data_lines        <= {DW{1'b0}};
      o_shared_data_lines_oe     <= 1'b0;
    end
    else
    begin
      power_armed <= 1'b1;
      state       <= (state == ST_POWER && !power_armed) ? ST_POWER : next_state;
      o_done      <= 1'b0;
      o_ready     <= (next_state == ST_IDLE) && power_armed;
      case (state)
        ST_IDLE:
        begin
          if (i_req)
          begin
            // Address goes out with the select edge, never after it
            o_mem_addr                 <= i_addr;
            o_chip_select_low_active_n <= 1'b0;
            o_chip_select_high_active  <= 1'b1;
            o_write_strobe_n           <= ~i_we;
            // Enable stays high in writes so the memory never fights our drive
            o_output_enable_n          <= i_we;
            o_shared_data_lines        <= i_wdata;
            o_shared_data_lines_oe     <= i_we;
          end
        end
        ST_RD:
        begin
          if (cnt_done)
          begin
            // Taken on the edge that drops the enable; the memory holds data past it
            o_rdata                    <= i_shared_data_lines;
            o_done                     <= 1'b1;
            o_output_enable_n          <= 1'b1;
            o_chip_select_low_active_n <= 1'b1;
            o_chip_select_high_active  <= 1'b0;
          end
        end
        ST_WR:
        begin
          // The strobe edge ends the write; the selects follow a cycle later
          if (cnt_done)
            o_write_strobe_n <= 1'b1;
        end
        ST_WEND:
        begin
          // Data and address held one cycle past the strobe edge
          o_shared_data_lines_oe     <= 1'b0;
          o_chip_select_low_active_n <= 1'b1;
          o_chip_select_high_active  <= 1'b0;
          o_done                     <= 1'b1;
        end
        default:
        begin
          o_done <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: core/asap_map.vh
// Constants and timing for the static memory host controller
// Function
// - Wait one millisecond after power before access
// - Data set up 5.5 ns before end
// - Address valid at start, 7 ns before end
// - Strobe low 7 ns, cycles 10 ns apart
// - Select active 7 ns before write end
// - Strobe high in reads; address before select (the controller drives address and select on the same edge)
`ifndef ASAP_MAP_VH
`define ASAP_MAP_VH
`define ASAP_CLK_PS        25000
`define ASAP_T_POWER_US    1000
`define ASAP_T_RC_PS       10000
`define ASAP_T_AA_PS       10000
`define ASAP_T_ACE_PS      10000
`define ASAP_T_DOE_PS      5000
`define ASAP_T_HZOE_PS     5000
`define ASAP_T_WC_PS       10000
`define ASAP_T_SCE_PS      7000
`define ASAP_T_AW_PS       7000
`define ASAP_T_PWE_PS      7000
`define ASAP_T_SD_PS       5500
`define ASAP_T_HZWE_PS     5000
`define ASAP_ADDR_W        21
`define ASAP_DATA_W        8
`define ASAP_CYC(ps)       (((ps) + `ASAP_CLK_PS - 1) / `ASAP_CLK_PS)
`define ASAP_POWER_CYC     ((`ASAP_T_POWER_US * 1000000 + `ASAP_CLK_PS - 1) / `ASAP_CLK_PS)
`endif

// file: tb/asap_chk.sv
// Pin protocol checks for the static memory host controller
`timescale 1ns/1ps
module asap_chk (
  // Clock and reset
  input logic        i_clk,
  input logic        i_rst,
  // Handshake
  input logic        o_ready,
  // Memory pins
  input logic        o_chip_select_low_active_n,
  input logic        o_chip_select_high_active,
  input logic        o_output_enable_n,
  input logic        o_write_strobe_n,
  input logic [20:0] o_mem_addr,
  input logic [7:0]  o_shared_data_lines,
  input logic        o_shared_data_lines_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire s = !o_chip_select_low_active_n && o_chip_select_high_active;
  wire w = o_write_strobe_n;
  wire r = o_output_enable_n;
  wire d = o_shared_data_lines_oe;
  a_read_strobe: assert property (!r |-> w)
    else $error("strobe in read");
  a_write_sel: assert property (!w |-> s && d)
    else $error("unselected write");
  a_strobe_space: assert property ($fell(w) |=> w ##1 w)
    else $error("strobe width");
  a_data_hold: assert property ($rose(w) |-> d && $stable(o_shared_data_lines))
    else $error("data moved");
  a_addr_hold: assert property (!w |=> $stable(o_mem_addr))
    else $error("addr in write");
  a_read_addr: assert property (!r |=> $stable(o_mem_addr))
    else $error("addr in read");
  a_no_fight: assert property (d |-> r)
    else $error("bus fight");
  a_idle_quiet: assert property (o_ready |-> !s && w && r)
    else $error("idle pins");
endmodule

bind asap_ctrl asap_chk i_chk (
  .i_clk                      (i_clk),
  .i_rst                      (i_rst),
  .o_ready                    (o_ready),
  .o_chip_select_low_active_n (o_chip_select_low_active_n),
  .o_chip_select_high_active  (o_chip_select_high_active),
  .o_output_enable_n          (o_output_enable_n),
  .o_write_strobe_n           (o_write_strobe_n),
  .o_mem_addr                 (o_mem_addr),
  .o_shared_data_lines        (o_shared_data_lines),
  .o_shared_data_lines_oe     (o_shared_data_lines_oe)
);

// file: tb/asap_mem.sv
// Behavioural model of the asynchronous byte-wide static memory
`timescale 1ns/1ps
module asap_mem (
  // Controls from the host
  input  logic        i_cs_n,
  input  logic        i_cs,
  input  logic        i_oe_n,
  input  logic        i_we_n,
  input  logic [20:0] i_addr,
  // Shared data lines
  input  logic [7:0]  i_data,
  output logic [7:0]  o_q
);
  logic [7:0] mem [int];
  wire sel = !i_cs_n && i_cs;
  wire wr  = sel && !i_we_n;
  wire rd  = sel && !i_oe_n && i_we_n;
  initial o_q = 8'h00;
  // Any qualifier dropping ends the write; zero data hold is enough
  always @(negedge wr) mem[i_addr] = i_data;
  // Undriven lines flip, so a late capture never sees the old byte
  always @(rd or i_addr)
  begin
    #3 o_q = ~o_q;
    #7 if (rd) o_q = mem[i_addr];
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
module testbench;
  localparam PWR = 20;
  logic        i_clk = 1'h0;
  logic        i_rst = 1'h1;
  logic        i_req = 1'h0;
  logic        i_we = 1'h0;
  logic [20:0] i_addr = 21'h0;
  logic [7:0]  i_wdata = 8'h0;
  wire         o_ready, o_done, o_output_enable_n, o_write_strobe_n, o_shared_data_lines_oe;
  wire         o_chip_select_low_active_n, o_chip_select_high_active;
  wire  [20:0] o_mem_addr;
  wire  [7:0]  o_rdata, o_shared_data_lines, q;
  wire  [7:0]  i_shared_data_lines = o_shared_data_lines_oe ? o_shared_data_lines : q;
  int          n_fail = 0;
  int          num_checks = 0;
  always #12.5 i_clk = ~i_clk;
  asap_ctrl #(
    .POWER_CYC (PWR)
  ) i_dut (
    .i_clk                      (i_clk),
    .i_rst                      (i_rst),
    .i_req                      (i_req),
    .i_we                       (i_we),
    .i_addr                     (i_addr),
    .i_wdata                    (i_wdata),
    .o_ready                    (o_ready),
    .o_done                     (o_done),
    .o_rdata                    (o_rdata),
    .o_chip_select_low_active_n (o_chip_select_low_active_n),
    .o_chip_select_high_active  (o_chip_select_high_active),
    .o_output_enable_n          (o_output_enable_n),
    .o_write_strobe_n           (o_write_strobe_n),
    .o_mem_addr                 (o_mem_addr),
    .i_shared_data_lines        (i_shared_data_lines),
    .o_shared_data_lines        (o_shared_data_lines),
    .o_shared_data_lines_oe     (o_shared_data_lines_oe)
  );
  asap_mem i_mem (.i_cs_n(o_chip_select_low_active_n), .i_cs(o_chip_select_high_active),
    .i_oe_n(o_output_enable_n), .i_we_n(o_write_strobe_n), .i_addr(o_mem_addr),
    .i_data(i_shared_data_lines), .o_q(q));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for ready (0) or done (1); n gives the cycles spent
  task automatic wait_for(input logic which, output int n);
    for (n = 1; n < 200; n++)
    begin
      @(posedge i_clk);
      #1;
      if ((which ? o_done : o_ready) === 1'h1)
        return;
    end
    n_fail++;
    end_sim();
  endtask
  task automatic access(input logic we, input logic [20:0] ad, input logic [7:0] wd);
    int n;
    wait_for(1'h0, n);
    @(negedge i_clk);
    i_req = 1'h1;
    i_we = we;
    i_addr = ad;
    i_wdata = wd;
    @(negedge i_clk);
    i_req = 1'h0;
    chk(o_ready, 0);
    wait_for(1'h1, n);
  endtask
  task automatic t_power;
    int n;
    wait_for(1'h0, n);
    chk(n >= PWR, 1);
  endtask
  // Extreme addresses and mixed bit patterns, written back to back
  task automatic t_rw;
    logic [20:0] ad [3] = '{21'h000000, 21'h1FFFFF, 21'h0AAAAA};
    logic [7:0]  wd [3] = '{8'hA5, 8'h5A, 8'h00};
    foreach (ad[i])
      access(1'h1, ad[i], wd[i]);
    foreach (ad[i])
    begin
      access(1'h0, ad[i], 8'hFF);
      chk(o_rdata, wd[i]);
    end
  endtask
  // Reset in mid-run parks the pins and restarts the power wait; memory keeps data
  task automatic t_reset;
    int         n;
    logic [5:0] pins;
    @(negedge i_clk);
    i_rst = 1'h1;
    repeat (4) @(negedge i_clk);
    pins = {o_ready, o_chip_select_low_active_n, o_chip_select_high_active,
            o_output_enable_n, o_write_strobe_n, o_shared_data_lines_oe};
    chk(pins, 6'h16);
    i_rst = 1'h0;
    wait_for(1'h0, n);
    chk(n >= PWR, 1);
    access(1'h0, 21'h1FFFFF, 8'hFF);
    chk(o_rdata, 8'h5A);
  endtask
  initial
  begin
    repeat (4) @(negedge i_clk);
    i_rst = 1'h0;
    t_power();
    t_rw();
    t_reset();
    end_sim();
  end
endmodule
